// ==== src/lsi_top.sv ====
/*
 * Digital side of a two-channel ambient light sensor: measurement
 * sequencer with integration and wait timing, result capture, threshold
 * compare with persistence filter, sticky interrupt status with mask and
 * an open-drain active-low interrupt pin, and a classic Wishbone slave.
 * Assumes the converter front end presents both channel counts, settled
 * and synchronous to clk, by the end of each integration period, and that
 * a serial bus front end turns host register traffic into Wishbone cycles.
 */

// Overview of operation
// RQ1: Both channels convert together; each result is up to 16 bits.
// RQ2: At end of conversion both results are copied into readable result registers.
// RQ3: Enabled threshold event drives a level interrupt held until host clears it.
// RQ4: Event when conversion is above upper or below lower threshold.
// RQ5: Interrupt only after programmed count of consecutive out-of-window conversions.
// RQ6: Interrupt pin is active low, open drain: pulled low or released.
// RQ7: Programmable wait between cycles, about 2.7 ms to over 8 seconds; the code stops at 256 steps of 2.73 ms, about 699 ms.
// RQ8: With sleep-after-interrupt selected, cycling stops once interrupt is asserted.
// RQ9: All register traffic arrives over a 400 kbit/s two-wire host link.
// RQ10: Host programs analog gain and integration time for each conversion.
// RQ11: Integration is 1 to 256 steps of 2.73 ms; all ones is one step.
// RQ12: Wait is 1 to 256 steps of 2.73 ms; all ones is one step.
// RQ13: Persistence counter clears on in-window result and on host interrupt clear.
// RQ14: Compare broadband channel unsigned against 16-bit upper and lower thresholds.
module lsi_top #(
    parameter int unsigned STEP_CYCLES = lsi_pkg::STEP_CYCLES,
    parameter int unsigned DATA_W      = lsi_pkg::DATA_W
) (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        wb_cyc,
    input  wire logic                        wb_stb,
    input  wire logic                        wb_we,
    input  wire logic [3:0]                  wb_sel,
    input  wire logic [lsi_pkg::ADR_W-1:0]   wb_adr,
    input  wire logic [31:0]                 wb_wdata,
    output logic      [31:0]                 wb_rdata,
    output logic                             wb_ack,
    input  wire logic [DATA_W-1:0]           broadband_channel,
    input  wire logic [DATA_W-1:0]           infrared_channel,
    output logic                             adc_integrate,
    output logic      [lsi_pkg::GAIN_W-1:0]  analog_gain_setting,
    input  wire logic                        irq_n_in,
    output logic                             irq_n_out,
    output logic                             irq_n_oe
);
    import lsi_pkg::*;

    // ------------------------------
    // Declarations
    // ------------------------------
    lsi_tmr_if tmr ();

    lsi_state_t         state_reg;
    lsi_state_t         state_next;
    logic [CTRL_W-1:0]  ctrl_reg;
    logic [SET_W-1:0]   integ_time_reg;
    logic [SET_W-1:0]   wait_time_reg;
    logic [GAIN_W-1:0]  gain_reg;
    logic [DATA_W-1:0]  thr_lo_reg;
    logic [DATA_W-1:0]  thr_hi_reg;
    logic [PERS_W-1:0]  persist_reg;
    logic [PERS_W-1:0]  pers_cnt_reg;
    logic [EVT_W-1:0]   status_reg;
    logic [EVT_W-1:0]   mask_reg;
    logic [DATA_W-1:0]  broadband_reg;
    logic [DATA_W-1:0]  infrared_reg;
    logic               valid_reg;
    logic               ack_reg;
    logic [31:0]        rdata_reg;

    logic               run;
    logic               conv_end;
    logic               outside;
    logic               pers_hit;
    logic               thr_set;
    logic [PERS_W-1:0]  pers_need;
    logic               wr_en;
    logic [ADR_W-1:0]   word_adr;
    logic [EVT_W-1:0]   evt_set;
    logic [EVT_W-1:0]   evt_clr;
    logic               host_clr_thr;

    // ------------------------------
    // Step timer
    // ------------------------------
    lsi_step_timer #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tmr     (tmr)
    );

    // ------------------------------
    // Measurement sequencer
    // ------------------------------
    assign run = ctrl_reg[CTRL_POWER] && ctrl_reg[CTRL_MEASURE];

    // A conversion ends when the integration timer expires while running.
    assign conv_end = (state_reg == ST_INTEG) && tmr.done && run; // RQ1

    // Next state and timer starts; dropping power or measure cancels at once.
    always_comb begin
        state_next = state_reg;
        tmr.start  = 1'b0;
        tmr.cancel = !run;
        tmr.steps  = lsi_steps(integ_time_reg); // RQ11
        unique case (state_reg)
            ST_IDLE: begin
                if (run) begin
                    state_next = ST_INTEG;
                    tmr.start  = 1'b1;
                end
            end
            ST_INTEG: begin
                if (!run) begin
                    state_next = ST_IDLE;
                end else if (tmr.done) begin
                    if (thr_set && ctrl_reg[CTRL_SLEEP]) begin
                        state_next = ST_SLEEP; // RQ8
                    end else if (ctrl_reg[CTRL_WAIT]) begin
                        state_next = ST_WAIT;
                        tmr.start  = 1'b1;
                        tmr.steps  = lsi_steps(wait_time_reg); // RQ7 RQ12
                    end else begin
                        tmr.start  = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                if (!run) begin
                    state_next = ST_IDLE;
                end else if (tmr.done) begin
                    state_next = ST_INTEG;
                    tmr.start  = 1'b1;
                end
            end
            ST_SLEEP: begin
                // Stays asleep until the host clears the threshold flag or drops power or measure.
                if (!run || !status_reg[STAT_THR]) begin
                    state_next = ST_IDLE; // RQ8
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // The front end integrates while in the integration state.
    assign adc_integrate       = (state_reg == ST_INTEG);
    assign analog_gain_setting = gain_reg; // RQ10

    // ------------------------------
    // Result capture
    // ------------------------------
    // Both channels are taken in the same cycle so they form one pair.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            broadband_reg <= RESULT_RST;
            infrared_reg  <= RESULT_RST;
            valid_reg     <= 1'b0;
        end else if (conv_end) begin
            broadband_reg <= broadband_channel; // RQ2
            infrared_reg  <= infrared_channel; // RQ2
            valid_reg     <= 1'b1;
        end
    end

    // ------------------------------
    // Threshold compare and persistence filter
    // ------------------------------
    // Unsigned compare of the fresh broadband count against the window.
    assign outside   = (broadband_channel > thr_hi_reg) ||
                       (broadband_channel < thr_lo_reg); // RQ4 RQ14
    // A persistence setting of zero behaves as one.
    assign pers_need = (persist_reg == '0) ? 4'h1 : persist_reg;
    assign pers_hit  = outside && ((pers_cnt_reg == '1) ||
                       (pers_cnt_reg + 4'h1 >= pers_need)); // RQ5
    assign thr_set   = conv_end && pers_hit && ctrl_reg[CTRL_INT_EN]; // RQ3

    // Consecutive out-of-window counter, saturating.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pers_cnt_reg <= '0;
        end else if (host_clr_thr || (conv_end && !outside)) begin
            pers_cnt_reg <= '0; // RQ13
        end else if (conv_end && (pers_cnt_reg != '1)) begin
            pers_cnt_reg <= pers_cnt_reg + 4'h1; // RQ5
        end
    end

    // ------------------------------
    // Interrupt status, mask and pin
    // ------------------------------
    assign evt_set      = {conv_end, thr_set};
    assign evt_clr      = (wr_en && (word_adr == REG_STATUS) && wb_sel[0]) ?
                          wb_wdata[EVT_W-1:0] : '0;
    assign host_clr_thr = evt_clr[STAT_THR];

    // Sticky flags; a new event in the clearing cycle wins.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_reg <= EVT_RST;
        end else begin
            status_reg <= (status_reg & ~evt_clr) | evt_set; // RQ3
        end
    end

    // Pin is only ever pulled low; released otherwise.
    assign irq_n_out = 1'b0; // RQ6
    assign irq_n_oe  = |(status_reg & mask_reg); // RQ3 RQ6

    // ------------------------------
    // Wishbone slave
    // ------------------------------
    // Register traffic from the serial host link arrives as these cycles.
    assign word_adr = {wb_adr[ADR_W-1:2], 2'b00}; // RQ9
    assign wr_en    = wb_cyc && wb_stb && wb_we && ack_reg;
    assign wb_ack   = ack_reg;
    assign wb_rdata = rdata_reg;

    // Acknowledge one cycle after the request; drop it the cycle after.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_cyc && wb_stb && !ack_reg;
        end
    end

    // Writes take effect on the edge where the acknowledge is sampled.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_reg       <= CTRL_RST;
            integ_time_reg <= INTEG_RST;
            wait_time_reg  <= WAIT_RST;
            gain_reg       <= GAIN_RST;
            thr_lo_reg     <= THR_LO_RST;
            thr_hi_reg     <= THR_HI_RST;
            persist_reg    <= PERSIST_RST;
            mask_reg       <= EVT_RST;
        end else if (wr_en) begin
            case (word_adr)
                REG_CTRL: begin
                    ctrl_reg <= CTRL_W'(lsi_merge(32'(ctrl_reg), wb_wdata, wb_sel));
                end
                REG_INTEG: begin
                    integ_time_reg <= SET_W'(lsi_merge(32'(integ_time_reg), wb_wdata,
                                                       wb_sel)); // RQ10
                end
                REG_WAIT: begin
                    wait_time_reg <= SET_W'(lsi_merge(32'(wait_time_reg), wb_wdata, wb_sel));
                end
                REG_GAIN: begin
                    gain_reg <= GAIN_W'(lsi_merge(32'(gain_reg), wb_wdata, wb_sel)); // RQ10
                end
                REG_THR_LO: begin
                    thr_lo_reg <= DATA_W'(lsi_merge(32'(thr_lo_reg), wb_wdata, wb_sel));
                end
                REG_THR_HI: begin
                    thr_hi_reg <= DATA_W'(lsi_merge(32'(thr_hi_reg), wb_wdata, wb_sel));
                end
                REG_PERSIST: begin
                    persist_reg <= PERS_W'(lsi_merge(32'(persist_reg), wb_wdata, wb_sel));
                end
                REG_IRQ_MASK: begin
                    mask_reg <= EVT_W'(lsi_merge(32'(mask_reg), wb_wdata, wb_sel));
                end
                default: begin
                end
            endcase
        end
    end

    // Read data is loaded with the acknowledge; unmapped words read zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= '0;
        end else if (wb_cyc && wb_stb && !wb_we && !ack_reg) begin
            case (word_adr)
                REG_CTRL:      rdata_reg <= 32'(ctrl_reg);
                REG_INTEG:     rdata_reg <= 32'(integ_time_reg);
                REG_WAIT:      rdata_reg <= 32'(wait_time_reg);
                REG_GAIN:      rdata_reg <= 32'(gain_reg);
                REG_THR_LO:    rdata_reg <= 32'(thr_lo_reg);
                REG_THR_HI:    rdata_reg <= 32'(thr_hi_reg);
                REG_PERSIST:   rdata_reg <= 32'(persist_reg);
                REG_STATUS: begin
                    rdata_reg                 <= 32'(status_reg);
                    rdata_reg[STAT_VALID]     <= valid_reg;
                    rdata_reg[STAT_SLEEP]     <= (state_reg == ST_SLEEP);
                    rdata_reg[STAT_PIN]       <= irq_n_in;
                end
                REG_IRQ_MASK:  rdata_reg <= 32'(mask_reg);
                REG_BROADBAND: rdata_reg <= 32'(broadband_reg); // RQ2
                REG_INFRARED:  rdata_reg <= 32'(infrared_reg); // RQ2
                default:       rdata_reg <= '0;
            endcase
        end
    end

endmodule

// ==== src/lsi_pkg.sv ====
/*
 * Shared constants, types and helpers for the light sensor threshold
 * interrupt block: register offsets, field positions, reset values,
 * the step timing and the measurement state encoding.
 * Assumes a single 100 MHz clock and a 32-bit classic Wishbone port.
 */
package lsi_pkg;

    // ------------------------------
    // Timing
    // ------------------------------
    localparam int unsigned CLK_FREQ_MHZ = 100;
    localparam real         STEP_TIME_MS = 2.73;
    // One nominal integration or wait step in clock cycles (nearest).
    localparam int unsigned STEP_CYCLES  =
        $rtoi(STEP_TIME_MS * 1000.0 * CLK_FREQ_MHZ + 0.5);

    // ------------------------------
    // Widths
    // ------------------------------
    localparam int unsigned DATA_W  = 16;
    localparam int unsigned SET_W   = 8;
    localparam int unsigned STEPS_W = 9;
    localparam int unsigned GAIN_W  = 2;
    localparam int unsigned PERS_W  = 4;
    localparam int unsigned ADR_W   = 8;
    localparam int unsigned EVT_W   = 2;

    // ------------------------------
    // Register byte offsets
    // ------------------------------
    localparam logic [ADR_W-1:0] REG_CTRL      = 8'h00;
    localparam logic [ADR_W-1:0] REG_INTEG     = 8'h04;
    localparam logic [ADR_W-1:0] REG_WAIT      = 8'h08;
    localparam logic [ADR_W-1:0] REG_GAIN      = 8'h0c;
    localparam logic [ADR_W-1:0] REG_THR_LO    = 8'h10;
    localparam logic [ADR_W-1:0] REG_THR_HI    = 8'h14;
    localparam logic [ADR_W-1:0] REG_PERSIST   = 8'h18;
    localparam logic [ADR_W-1:0] REG_STATUS    = 8'h1c;
    localparam logic [ADR_W-1:0] REG_IRQ_MASK  = 8'h20;
    localparam logic [ADR_W-1:0] REG_BROADBAND = 8'h24;
    localparam logic [ADR_W-1:0] REG_INFRARED  = 8'h28;

    // ------------------------------
    // Field positions
    // ------------------------------
    localparam int unsigned CTRL_POWER   = 0;
    localparam int unsigned CTRL_MEASURE = 1;
    localparam int unsigned CTRL_WAIT    = 2;
    localparam int unsigned CTRL_INT_EN  = 3;
    localparam int unsigned CTRL_SLEEP   = 4;
    localparam int unsigned CTRL_W       = 5;
    localparam int unsigned STAT_THR     = 0;
    localparam int unsigned STAT_CONV    = 1;
    localparam int unsigned STAT_VALID   = 2;
    localparam int unsigned STAT_SLEEP   = 3;
    localparam int unsigned STAT_PIN     = 4;

    // ------------------------------
    // Reset values
    // ------------------------------
    localparam logic [CTRL_W-1:0] CTRL_RST    = 5'h00;
    localparam logic [SET_W-1:0]  INTEG_RST   = 8'hff;
    localparam logic [SET_W-1:0]  WAIT_RST    = 8'hff;
    localparam logic [GAIN_W-1:0] GAIN_RST    = 2'h0;
    localparam logic [DATA_W-1:0] THR_LO_RST  = 16'h0000;
    localparam logic [DATA_W-1:0] THR_HI_RST  = 16'hffff;
    localparam logic [PERS_W-1:0] PERSIST_RST = 4'h0;
    localparam logic [EVT_W-1:0]  EVT_RST     = 2'h0;
    localparam logic [DATA_W-1:0] RESULT_RST  = 16'h0000;

    // ------------------------------
    // Types and helpers
    // ------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_INTEG = 2'b01,
        ST_WAIT  = 2'b10,
        ST_SLEEP = 2'b11
    } lsi_state_t;

    // Step count from a setting: all ones gives one step, zero gives 256.
    function automatic logic [STEPS_W-1:0] lsi_steps(input logic [SET_W-1:0] setting);
        return 9'h100 - {1'b0, setting};
    endfunction

    // Merge write data into a word under the byte enables.
    function automatic logic [31:0] lsi_merge(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0]  sel);
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

// ==== src/lsi_tmr_if.sv ====
/*
 * Interface between the measurement sequencer and its step timer.
 * Assumes both ends run on the same clock.
 */
interface lsi_tmr_if;
    import lsi_pkg::*;

    logic               start;
    logic               cancel;
    logic [STEPS_W-1:0] steps;
    logic               done;
    logic               busy;

    modport seq   (output start, output cancel, output steps, input done, input busy);
    modport timer (input start, input cancel, input steps, output done, output busy);
endinterface

// ==== src/lsi_step_timer.sv ====
/*
 * Step timer: counts a given number of steps of STEP_CYCLES clocks each
 * and pulses done once after the last one.
 * Assumes STEP_CYCLES is at least 2 and start is a one-cycle pulse.
 */
module lsi_step_timer #(
    parameter int unsigned STEP_CYCLES = lsi_pkg::STEP_CYCLES
) (
    input  wire logic  clk,
    input  wire logic  sys_rst,
    lsi_tmr_if.timer   tmr
);
    import lsi_pkg::*;

    localparam int unsigned       CYC_W   = $clog2(STEP_CYCLES);
    localparam logic [CYC_W-1:0]  CYC_MAX = CYC_W'(STEP_CYCLES - 1);

    logic [CYC_W-1:0]   cyc_reg;
    logic [STEPS_W-1:0] steps_reg;
    logic               busy_reg;
    logic               done_reg;
    logic               last_cycle;

    assign last_cycle = busy_reg && (cyc_reg == '0) && (steps_reg == 9'h001);
    assign tmr.busy   = busy_reg;
    assign tmr.done   = done_reg;

    // ------------------------------
    // Step and cycle counting
    // ------------------------------
    // A new start reloads the counters, so a restart never merges with an old run.
    always_ff @(posedge clk) begin
        if (sys_rst || tmr.cancel) begin
            busy_reg  <= 1'b0;
            cyc_reg   <= '0;
            steps_reg <= '0;
        end else if (tmr.start) begin
            busy_reg  <= 1'b1;
            cyc_reg   <= CYC_MAX;
            steps_reg <= tmr.steps;
        end else if (busy_reg) begin
            if (cyc_reg != '0) begin
                cyc_reg <= cyc_reg - 1'b1;
            end else if (steps_reg == 9'h001) begin
                busy_reg <= 1'b0;
            end else begin
                steps_reg <= steps_reg - 1'b1;
                cyc_reg   <= CYC_MAX;
            end
        end
    end

    // Done pulses for one cycle after the last cycle of the last step.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= last_cycle && !tmr.start && !tmr.cancel;
        end
    end

endmodule

// ==== sim/lsi_props.sv ====
/*
 * Checker for the light sensor block: bus answer timing, read data and
 * gain stability, interrupt pin drive, hold and cause.
 * Assumes it is bound to lsi_top and sees only that module's ports.
 */
module lsi_props (
    input wire logic                       clk,
    input wire logic                       sys_rst,
    input wire logic                       wb_cyc,
    input wire logic                       wb_stb,
    input wire logic                       wb_we,
    input wire logic [31:0]                wb_rdata,
    input wire logic                       wb_ack,
    input wire logic                       adc_integrate,
    input wire logic [lsi_pkg::GAIN_W-1:0] analog_gain_setting,
    input wire logic                       irq_n_out,
    input wire logic                       irq_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // All checks run on clk and rest while reset is high.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_req; wb_cyc && wb_stb && !wb_ack; endsequence
    sequence s_pulse; wb_ack ##1 !wb_ack; endsequence
    property p_ack_next; s_req |=> s_pulse; endproperty
    property p_no_req; !(wb_cyc && wb_stb) |=> !wb_ack; endproperty
    property p_ack_cause; wb_ack |-> $past(wb_cyc && wb_stb); endproperty
    property p_rdata_src; !$stable(wb_rdata) |-> wb_ack && !wb_we; endproperty
    property p_gain_src; !$stable(analog_gain_setting) |-> $past(wb_ack && wb_we); endproperty
    property p_pin_low; irq_n_oe |-> irq_n_out == 1'b0; endproperty
    property p_irq_hold; irq_n_oe && !(wb_ack && wb_we) |=> irq_n_oe; endproperty
    property p_irq_cause; $rose(irq_n_oe) |-> $past(adc_integrate) || $past(wb_ack && wb_we);
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("ack not one cycle after request");
    a_no_req: assert property (p_no_req)
        else $error("ack without request");
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack not preceded by request");
    a_rdata_src: assert property (p_rdata_src)
        else $error("read data moved outside a read answer");
    a_gain_src: assert property (p_gain_src)
        else $error("gain moved without a write");
    a_pin_low: assert property (p_pin_low)
        else $error("interrupt pin driven high");
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt released without host write");
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt raised without conversion end or write");
endmodule

bind lsi_top lsi_props u_props (.clk(clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_rdata(wb_rdata), .wb_ack(wb_ack), .adc_integrate(adc_integrate),
    .analog_gain_setting(analog_gain_setting), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

// ==== sim/lsi_adc_model.sv ====
/*
 * Converter front end model: shows the light levels while integrating.
 * Assumes the bench sets the levels; outside integration it shows their
 * inverse so that a capture at the wrong moment is seen.
 */
module lsi_adc_model (
    input wire logic                        adc_integrate,
    input wire logic [lsi_pkg::DATA_W-1:0]  bb_lvl,
    input wire logic [lsi_pkg::DATA_W-1:0]  ir_lvl,
    output logic     [lsi_pkg::DATA_W-1:0]  broadband_channel,
    output logic     [lsi_pkg::DATA_W-1:0]  infrared_channel
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both channels follow the same integration window.
    assign broadband_channel = adc_integrate ? bb_lvl : ~bb_lvl;
    assign infrared_channel  = adc_integrate ? ir_lvl : ~ir_lvl;
endmodule

// ==== sim/lsi_tb_top.sv ====
/*
 * Testbench for lsi_top: Wishbone tasks, converter model, interrupt wire.
 * Assumes STEP_CYCLES of 4 so that a step lasts four clocks.
 */
module lsi_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lsi_pkg::*;
    logic        clk = 0, sys_rst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0;
    logic [7:0]  wb_adr = 0;
    logic [31:0] wb_wdata = 0, wb_rdata, rd;
    logic        wb_ack, adc_integrate, irq_n_out, irq_n_oe, irq_wire;
    logic [1:0]  gain;
    logic [15:0] bb, ir, bb_lvl = 16'h1234, ir_lvl = 16'h0567;
    logic [7:0]  ra [6] = '{REG_CTRL, REG_INTEG, REG_WAIT, REG_THR_HI, 8'h40, REG_STATUS};
    logic [31:0] rv [6] = '{32'h0, 32'hff, 32'hff, 32'hffff, 32'h0, 32'h10};
    int          err_count = 0, total_checks = 0, cycles = 0, n;
    // Clock and the pulled-up interrupt wire.
    always #5 clk = ~clk;
    assign irq_wire = irq_n_oe ? irq_n_out : 1'b1;
    lsi_top #(.STEP_CYCLES(4)) DUT (.clk(clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_sel(4'hf), .wb_adr(wb_adr), .wb_wdata(wb_wdata),
        .wb_rdata(wb_rdata), .wb_ack(wb_ack), .broadband_channel(bb), .infrared_channel(ir),
        .adc_integrate(adc_integrate), .analog_gain_setting(gain), .irq_n_in(irq_wire),
        .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
    lsi_adc_model u_adc (.adc_integrate(adc_integrate), .bb_lvl(bb_lvl), .ir_lvl(ir_lvl),
        .broadband_channel(bb), .infrared_channel(ir));
    // One bus cycle, held until the ack edge.
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdata} <= {2'b11, w, a, d};
        do @(posedge clk); while (wb_ack !== 1'b1);
        rd = wb_rdata;
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    // Polls until a conversion ends, then clears its flag.
    task automatic wait_conv;
        rd = 0;
        while (rd[1] !== 1'b1) wb_xfer(0, REG_STATUS, 0);
        wb_xfer(1, REG_STATUS, 32'h2);
    endtask
    // Length of one whole phase of the integrate output at level lv.
    task automatic span(input logic lv);
        n = 0;
        while (adc_integrate === lv) @(posedge clk);
        while (adc_integrate !== lv) @(posedge clk);
        while (adc_integrate === lv) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end
    // Main sequence.
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 0;
        foreach (ra[i]) begin
            wb_xfer(0, ra[i], 0);
            chk("reset value", rv[i], rd);
        end
        wb_xfer(1, 8'h40, 32'h5a);
        wb_xfer(0, 8'h40, 0);
        chk("unmapped", 0, rd);
        $display("test registers done");
        wb_xfer(1, REG_GAIN, 32'h3);
        wb_xfer(1, REG_WAIT, 32'hf0);
        wb_xfer(1, REG_INTEG, 32'hfe);
        wb_xfer(1, REG_CTRL, 32'h07);
        wait_conv();
        wb_xfer(0, REG_BROADBAND, 0);
        chk("broadband", 32'h1234, rd);
        wb_xfer(0, REG_INFRARED, 0);
        chk("infrared", 32'h0567, rd);
        chk("gain", 32'h3, {30'h0, gain});
        span(1);
        chk("integration span", 1, n >= 8 && n <= 10);
        span(0);
        chk("wait span", 1, n >= 64 && n <= 67);
        $display("test conversion done");
        wb_xfer(1, REG_THR_HI, 32'h1000);
        wb_xfer(1, REG_THR_LO, 32'h0100);
        wb_xfer(1, REG_PERSIST, 32'h2);
        wb_xfer(1, REG_IRQ_MASK, 32'h1);
        wb_xfer(1, REG_CTRL, 32'h0f);
        wb_xfer(1, REG_STATUS, 32'h3);
        wait_conv();
        wb_xfer(0, REG_STATUS, 0);
        chk("one out", 0, rd[0]);
        wait_conv();
        wb_xfer(0, REG_STATUS, 0);
        chk("two out", 1, rd[0]);
        chk("pin low", 0, irq_wire);
        wb_xfer(1, REG_IRQ_MASK, 0);
        @(posedge clk);
        chk("masked pin", 1, irq_wire);
        wb_xfer(1, REG_IRQ_MASK, 32'h1);
        bb_lvl <= 16'h0050;
        wb_xfer(1, REG_STATUS, 32'h1);
        @(posedge clk);
        chk("cleared pin", 1, irq_wire);
        wait_conv();
        wb_xfer(0, REG_STATUS, 0);
        chk("count restarts", 0, rd[0]);
        wait_conv();
        wb_xfer(0, REG_STATUS, 0);
        chk("below low", 1, rd[0]);
        bb_lvl <= 16'h2000;
        wb_xfer(1, REG_STATUS, 32'h1);
        wait_conv();
        bb_lvl <= 16'h0800;
        wait_conv();
        bb_lvl <= 16'h2000;
        wait_conv();
        wb_xfer(0, REG_STATUS, 0);
        chk("in window resets", 0, rd[0]);
        $display("test threshold done");
        wb_xfer(1, REG_PERSIST, 0);
        wb_xfer(1, REG_CTRL, 32'h1f);
        wb_xfer(1, REG_STATUS, 32'h3);
        wait_conv();
        repeat (200) @(posedge clk);
        chk("no cycling", 0, adc_integrate);
        chk("pin held", 0, irq_wire);
        wb_xfer(0, REG_STATUS, 0);
        chk("sleep status", 32'hd, rd);
        wb_xfer(1, REG_CTRL, 32'h03);
        wb_xfer(1, REG_STATUS, 32'h3);
        wait_conv();
        chk("no wait", 1, adc_integrate);
        $display("test sleep done");
        conclude();
    end
endmodule
